// ### pkg/pmsq_pkg.sv
// Constants and types for the power mode sequencer
package pmsq_pkg;

    // --------------------------------------------------------------
    // Clock and tick timing
    // --------------------------------------------------------------
    localparam int CLK_PERIOD_NS  = 5;
    localparam int MS_NS          = 1000000;
    localparam int TICK_PERIOD_NS = 1000000;  // 1 kHz sequencer tick
    localparam int TICK_CYCLES_DEFAULT = TICK_PERIOD_NS / CLK_PERIOD_NS;

    // --------------------------------------------------------------
    // Times in ms and their counts in ticks
    // --------------------------------------------------------------
    localparam int DEGLITCH_MS     = 32;
    localparam int REF_WAIT_MS     = 5;
    localparam int ACK_DEADLINE_MS = 128;
    localparam int ABORT_GAP_MS    = 2;
    localparam int BATT_LOW_MS     = 5;
    localparam logic [5:0] DEGLITCH_TICKS =
        6'(DEGLITCH_MS * MS_NS / TICK_PERIOD_NS);
    localparam logic [7:0] REF_WAIT_TICKS =
        8'(REF_WAIT_MS * MS_NS / TICK_PERIOD_NS);
    localparam logic [7:0] ACK_TICKS =
        8'(ACK_DEADLINE_MS * MS_NS / TICK_PERIOD_NS);
    localparam logic [7:0] ABORT_TICKS =
        8'(ABORT_GAP_MS * MS_NS / TICK_PERIOD_NS);
    // Longer than the low time: one tick beyond it
    localparam logic [2:0] BATT_LOW_TICKS =
        3'(BATT_LOW_MS * MS_NS / TICK_PERIOD_NS + 1);
    localparam logic [5:0] SEQ_MAX = 6'h3F;

    // --------------------------------------------------------------
    // Register map
    // --------------------------------------------------------------
    localparam logic [7:0] REG_POWER_ON_EVENT   = 8'h00;
    localparam logic [7:0] POWER_ON_EVENT_RESET = 8'h00;
    localparam int BIT_ACK  = 4;
    localparam int BIT_BATT = 3;
    localparam int BIT_BTN  = 2;
    localparam int BIT_ADP  = 1;
    localparam int BIT_USB  = 0;

    // --------------------------------------------------------------
    // Sequenced outputs and default on delays in ms
    // --------------------------------------------------------------
    localparam int OUT_LIN   = 0;
    localparam int OUT_CORE  = 1;
    localparam int OUT_SEC   = 2;
    localparam int OUT_THIRD = 3;
    localparam int OUT_RST   = 4;
    localparam int NUM_OUT   = 5;
    localparam logic [5:0] LINEAR_REG_DELAY_MS    = 6'h05;
    localparam logic [5:0] CORE_DELAY_MS          = 6'h0F;
    localparam logic [5:0] SECOND_DELAY_MS        = 6'h14;
    localparam logic [5:0] THIRD_DELAY_MS         = 6'h19;
    localparam logic [5:0] RESET_RELEASE_DELAY_MS = 6'h3C;

    // --------------------------------------------------------------
    // Synchronised inputs and deglitch filters
    // --------------------------------------------------------------
    localparam int IN_BTN   = 0;
    localparam int IN_ADP   = 1;
    localparam int IN_USB   = 2;
    localparam int IN_ACK   = 3;
    localparam int IN_UVLO  = 4;
    localparam int IN_ALARM = 5;
    localparam int IN_LOW   = 6;
    localparam int NUM_IN   = 7;
    localparam int NUM_FILT = 3;

    typedef enum logic [2:0] {
        S_OFF, S_STANDBY, S_REF, S_ON, S_ABORT, S_DOWN, S_CHG
    } pmsq_state_type;

    typedef enum logic [1:0] {
        BTN_RISE, BTN_FALL, BTN_HIGH, BTN_LOW
    } pmsq_button_type;

endpackage

// ### verilog/pmsq_sequencer.sv
// Operating mode state machine and power on/off sequencer
// Function
// - Standby leaves for Active only on button, adapter or USB wake.
// - Standby drops to Power Off when battery is not above lockout.
// - Battery insertion skips Standby if above alarm level, else Standby.
// - After wake, enable references, wait 5 ms, then start delays.
// - Each supply group and reset has own 0..63 ms factory delay.
// - 6-bit 1 kHz counter counts up from 0, down from 63.
// - Counting up past an output's delay enables it or releases reset.
// - Counting down below an output's delay disables it or asserts reset.
// - Defaults: linear 5, core 15, second 20, third 25, reset 60 ms.
// - Off delay is 63 minus on delay, giving reverse order.
// - Button wake mode selectable, 32 ms deglitch, drives status output.
// - No ack, no supply: reset low, supplies off 2 ms later, Standby.
// - No ack with supply: same abort, then Charger Standby.
// - Deglitched adapter starts sequencer whatever the battery voltage.
// - USB starts only above alarm level, else waits for charging.
// - Four read-only cause flags, cleared on power off.
// - Button in Active only changes status output, no power down.
// - Ack withdrawal with external supply present does not power down.
// - Supply removal keeps Active unless battery low alarm or no ack.
// - Charger Standby: outputs off, wake goes Active, no supply Standby.
// - Reset output open-drain, low in Off, Standby, Charger Standby.
// - Battery below low level over 5 ms with no external supply forces Power Off.
`timescale 1ns/1ps
`default_nettype none

module pmsq_sequencer #(
    parameter int TICK_CYCLES = pmsq_pkg::TICK_CYCLES_DEFAULT,
    parameter pmsq_pkg::pmsq_button_type BUTTON_MODE = pmsq_pkg::BTN_FALL,
    parameter logic [5:0] LINEAR_REG_DELAY = pmsq_pkg::LINEAR_REG_DELAY_MS,
    parameter logic [5:0] CORE_DELAY = pmsq_pkg::CORE_DELAY_MS,
    parameter logic [5:0] SECOND_DELAY = pmsq_pkg::SECOND_DELAY_MS,
    parameter logic [5:0] THIRD_DELAY = pmsq_pkg::THIRD_DELAY_MS,
    parameter logic [5:0] RESET_RELEASE_DELAY =
        pmsq_pkg::RESET_RELEASE_DELAY_MS
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Wake and supply detection pins
    input  wire logic       push_button_wake,
    input  wire logic       adapter_supply_in,
    input  wire logic       usb_supply_detect,
    input  wire logic       host_ack_pin,
    // Battery comparators, high while above the level
    input  wire logic       above_lockout_level,
    input  wire logic       above_battery_alarm_level,
    input  wire logic       above_battery_low_level,
    // Register port
    input  wire logic [7:0] reg_addr,
    input  wire logic       reg_wr,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    // Supply enables
    output logic            references_en,
    output logic            linear_reg_en,
    output logic            core_switcher_en,
    output logic            second_switcher_en,
    output logic            third_switcher_en,
    output logic            charger_default_mode,
    // Open-drain pins
    output logic            system_reset_n_out,
    output logic            system_reset_n_oe,
    output logic            button_status_out_out,
    output logic            button_status_out_oe
);
    import pmsq_pkg::*;

    localparam int DIV_W = $clog2(TICK_CYCLES);

    pmsq_state_type  state;
    logic [NUM_IN-1:0] sync1, sync2;
    logic [DIV_W-1:0]  div_cnt;
    logic              tick;
    logic [NUM_FILT-1:0] raw, dg, dg_d;
    logic [5:0]        filt_cnt [NUM_FILT];
    logic [5:0]        dly [NUM_OUT];
    logic [NUM_OUT-1:0] en;
    logic [7:0]        tmr;
    logic [5:0]        seq_cnt;
    logic [2:0]        low_cnt;
    logic [3:0]        flags;
    logic              host_ack_bit, acked, usb_pend, uvlo_d;
    logic              ext, ack_now, alarm_ok, uvlo_ok, uvlo_rise;
    logic              btn_ev, adp_ev, usb_go, wake, idle;
    logic              batt_dead, start_now;

    // --------------------------------------------------------------
    // Input synchronisers and 1 kHz tick
    // --------------------------------------------------------------
    // Every wake, supply, ack and battery pin is asynchronous; only sync2 is used by logic
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync1 <= '0;
            sync2 <= '0;
        end else begin
            sync1 <= {above_battery_low_level, above_battery_alarm_level,
                      above_lockout_level, host_ack_pin,
                      usb_supply_detect, adapter_supply_in,
                      push_button_wake};
            sync2 <= sync1;
        end
    end

    // Divider for the sequencer tick
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div_cnt <= '0;
            tick    <= 1'b0;
        end else begin
            tick <= (div_cnt == DIV_W'(TICK_CYCLES - 1));
            if (div_cnt == DIV_W'(TICK_CYCLES - 1))
                div_cnt <= '0;
            else
                div_cnt <= div_cnt + 1'b1;
        end
    end

    // --------------------------------------------------------------
    // Deglitch filters
    // --------------------------------------------------------------
    assign raw = {sync2[IN_USB], sync2[IN_ADP], sync2[IN_BTN]};

    // A level is taken only after it stands for the full count
    for (genvar f = 0; f < NUM_FILT; f++) begin : g_filt
        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                dg[f]       <= 1'b0;
                filt_cnt[f] <= '0;
            end else if (raw[f] == dg[f]) begin
                filt_cnt[f] <= '0;
            end else if (tick) begin
                if (filt_cnt[f] == DEGLITCH_TICKS - 6'h01) begin
                    dg[f]       <= raw[f];
                    filt_cnt[f] <= '0;
                end else begin
                    filt_cnt[f] <= filt_cnt[f] + 6'h01;
                end
            end
        end
    end

    // Previous filtered levels and synchronised lockout level for edge detection
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dg_d   <= '0;
            uvlo_d <= 1'b0;
        end else begin
            dg_d   <= dg;
            uvlo_d <= sync2[IN_UVLO];
        end
    end

    // --------------------------------------------------------------
    // Wake events
    // --------------------------------------------------------------
    assign ext       = dg[IN_ADP] | dg[IN_USB];
    assign ack_now   = host_ack_bit | sync2[IN_ACK];
    assign alarm_ok  = sync2[IN_ALARM];
    assign uvlo_ok   = sync2[IN_UVLO];
    assign uvlo_rise = uvlo_ok & ~uvlo_d;
    assign adp_ev    = dg[IN_ADP] & ~dg_d[IN_ADP];
    assign usb_go    = usb_pend & alarm_ok;
    assign idle      = (state == S_OFF) || (state == S_STANDBY) ||
                       (state == S_CHG);

    // Button wake condition chosen at build time
    always_comb begin
        case (BUTTON_MODE)
            BTN_RISE: btn_ev = dg[IN_BTN] & ~dg_d[IN_BTN];
            BTN_FALL: btn_ev = ~dg[IN_BTN] & dg_d[IN_BTN];
            BTN_HIGH: btn_ev = dg[IN_BTN];
            BTN_LOW:  btn_ev = ~dg[IN_BTN];
            default:  btn_ev = 1'b0;
        endcase
    end

    assign wake = btn_ev | adp_ev | usb_go;

    // USB arrival waits here until the battery reaches the alarm level
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            usb_pend <= 1'b0;
        else if (!dg[IN_USB] || start_now || !idle)
            usb_pend <= 1'b0;
        else if (dg[IN_USB] && !dg_d[IN_USB])
            usb_pend <= 1'b1;
    end

    // Start of a power-on from any idle state
    always_comb begin
        case (state)
            S_OFF:     start_now = adp_ev || (uvlo_rise && alarm_ok);
            S_STANDBY: start_now = uvlo_ok && wake;
            S_CHG:     start_now = wake;
            default:   start_now = 1'b0;
        endcase
        start_now = start_now && !batt_dead;
    end

    // --------------------------------------------------------------
    // Battery low supervisor
    // --------------------------------------------------------------
    // An external supply holds the part up whatever the battery does
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            low_cnt <= '0;
        else if (sync2[IN_LOW] || ext)
            low_cnt <= '0;
        else if (tick && low_cnt != BATT_LOW_TICKS)
            low_cnt <= low_cnt + 3'h1;
    end

    assign batt_dead = (low_cnt == BATT_LOW_TICKS) && (state != S_OFF);

    // --------------------------------------------------------------
    // Mode state machine
    // --------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state   <= S_OFF;
            tmr     <= '0;
            seq_cnt <= '0;
            acked   <= 1'b0;
        end else if (batt_dead) begin
            state <= S_OFF;
            tmr   <= '0;
        end else begin
            case (state)
                S_OFF: begin
                    tmr <= '0;
                    if (start_now)
                        state <= S_REF;
                    else if (uvlo_rise)
                        state <= S_STANDBY;
                end
                S_STANDBY: begin
                    tmr <= '0;
                    if (!uvlo_ok)
                        state <= S_OFF;
                    else if (start_now)
                        state <= S_REF;
                end
                S_CHG: begin
                    tmr <= '0;
                    if (start_now)
                        state <= S_REF;
                    else if (!ext)
                        state <= S_STANDBY;
                end
                S_REF: begin
                    if (tick) begin
                        tmr <= tmr + 8'h01;
                        if (tmr == REF_WAIT_TICKS - 8'h01) begin
                            state   <= S_ON;
                            tmr     <= '0;
                            seq_cnt <= '0;
                            acked   <= 1'b0;
                        end
                    end
                end
                S_ON: begin
                    if (tick && seq_cnt != SEQ_MAX)
                        seq_cnt <= seq_cnt + 6'h01;
                    if (ack_now)
                        acked <= 1'b1;
                    if (!acked && !ack_now) begin
                        if (tick) begin
                            tmr <= tmr + 8'h01;
                            if (tmr == ACK_TICKS - 8'h01) begin
                                state <= S_ABORT;
                                tmr   <= '0;
                            end
                        end
                    end else if (acked && !ext &&
                                 (!ack_now || !alarm_ok)) begin
                        state   <= S_DOWN;
                        seq_cnt <= SEQ_MAX;
                    end
                end
                S_ABORT: begin
                    if (tick) begin
                        tmr <= tmr + 8'h01;
                        if (tmr == ABORT_TICKS - 8'h01)
                            state <= ext ? S_CHG : S_STANDBY;
                    end
                end
                S_DOWN: begin
                    if (tick) begin
                        if (seq_cnt == '0)
                            state <= S_STANDBY;
                        else
                            seq_cnt <= seq_cnt - 6'h01;
                    end
                end
                default: state <= S_OFF;
            endcase
        end
    end

    // --------------------------------------------------------------
    // Output comparators
    // --------------------------------------------------------------
    assign dly[OUT_LIN]   = LINEAR_REG_DELAY;
    assign dly[OUT_CORE]  = CORE_DELAY;
    assign dly[OUT_SEC]   = SECOND_DELAY;
    assign dly[OUT_THIRD] = THIRD_DELAY;
    assign dly[OUT_RST]   = RESET_RELEASE_DELAY;

    // One comparator per output; same value sets on and off times
    for (genvar i = 0; i < NUM_OUT; i++) begin : g_out
        always_ff @(posedge clk or posedge rst) begin
            if (rst)
                en[i] <= 1'b0;
            else if (idle || state == S_REF)
                en[i] <= 1'b0;
            else if (state == S_ABORT && i == OUT_RST)
                en[i] <= 1'b0;
            else if (state == S_ON && seq_cnt > dly[i])
                en[i] <= 1'b1;
            else if (state == S_DOWN && seq_cnt < dly[i])
                en[i] <= 1'b0;
        end

        property p_on_cause;
            @(posedge clk) disable iff (rst)
            $rose(en[i]) |-> $past(seq_cnt) > dly[i];
        endproperty
        a_on_cause: assert property (p_on_cause)
            else $error("output enabled before its delay");

        property p_off_cause;
            @(posedge clk) disable iff (rst)
            $fell(en[i]) && $past(state) == S_DOWN
                |-> $past(seq_cnt) < dly[i];
        endproperty
        a_off_cause: assert property (p_off_cause)
            else $error("output disabled before its off delay");
    end

    // --------------------------------------------------------------
    // Power on event register
    // --------------------------------------------------------------
    // A new cause wins over the clear of the previous power cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            flags <= POWER_ON_EVENT_RESET[3:0];
        else if (start_now)
            flags <= {state == S_OFF && uvlo_rise, btn_ev && !adp_ev,
                      adp_ev, usb_go && !adp_ev && !btn_ev};
        else if (idle)
            flags <= '0;
    end

    // Host write wins over the hardware clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            host_ack_bit <= POWER_ON_EVENT_RESET[BIT_ACK];
        else if (reg_wr && reg_addr == REG_POWER_ON_EVENT)
            host_ack_bit <= reg_wdata[BIT_ACK];
        else if (idle)
            host_ack_bit <= 1'b0;
    end

    // Unmapped addresses read as zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            reg_rdata <= '0;
        else if (reg_addr == REG_POWER_ON_EVENT)
            reg_rdata <= {3'h0, host_ack_bit, flags};
        else
            reg_rdata <= '0;
    end

    // --------------------------------------------------------------
    // Outputs
    // --------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            references_en        <= 1'b0;
            charger_default_mode <= 1'b0;
        end else begin
            references_en        <= !idle;
            charger_default_mode <= (state == S_CHG);
        end
    end

    assign linear_reg_en         = en[OUT_LIN];
    assign core_switcher_en      = en[OUT_CORE];
    assign second_switcher_en    = en[OUT_SEC];
    assign third_switcher_en     = en[OUT_THIRD];
    assign system_reset_n_out    = 1'b0;
    assign system_reset_n_oe     = ~en[OUT_RST];
    assign button_status_out_out = 1'b0;
    // Status follows the filtered button only; it never powers down
    assign button_status_out_oe  = ~dg[IN_BTN];

    // --------------------------------------------------------------
    // Checks
    // --------------------------------------------------------------
    property p_reset_idle;
        @(posedge clk) disable iff (rst)
        ##1 $past(idle) |-> system_reset_n_oe;
    endproperty
    a_reset_idle: assert property (p_reset_idle)
        else $error("reset released while idle");

    property p_ref_wait;
        @(posedge clk) disable iff (rst)
        $rose(state == S_ON) |-> $past(state == S_REF, 1) ##0
            $past(tmr) == REF_WAIT_TICKS - 8'h01;
    endproperty
    a_ref_wait: assert property (p_ref_wait)
        else $error("sequencer started before reference wait");

    property p_ack_timeout;
        @(posedge clk) disable iff (rst)
        state == S_ON && !acked && !ack_now && tick && !batt_dead &&
            tmr == ACK_TICKS - 8'h01 |=> state == S_ABORT;
    endproperty
    a_ack_timeout: assert property (p_ack_timeout)
        else $error("missing ack did not abort");

    property p_abort_reset;
        @(posedge clk) disable iff (rst)
        state == S_ABORT ##1 state == S_ABORT |-> system_reset_n_oe;
    endproperty
    a_abort_reset: assert property (p_abort_reset)
        else $error("reset not driven during abort");

    property p_abort_exit;
        @(posedge clk) disable iff (rst)
        $fell(state == S_ABORT) && !$past(batt_dead)
            |-> state == ($past(ext) ? S_CHG : S_STANDBY);
    endproperty
    a_abort_exit: assert property (p_abort_exit)
        else $error("abort entered the wrong standby state");

    property p_ext_holds;
        @(posedge clk) disable iff (rst)
        state == S_ON && ext |=> state != S_DOWN;
    endproperty
    a_ext_holds: assert property (p_ext_holds)
        else $error("power down with external supply present");

    property p_ack_holds;
        @(posedge clk) disable iff (rst)
        state == S_ON && ack_now && alarm_ok |=> state != S_DOWN;
    endproperty
    a_ack_holds: assert property (p_ack_holds)
        else $error("power down while acknowledged");

    property p_lockout;
        @(posedge clk) disable iff (rst)
        state == S_STANDBY && !uvlo_ok |=> state == S_OFF;
    endproperty
    a_lockout: assert property (p_lockout)
        else $error("standby held below lockout");

    property p_flags_clear;
        @(posedge clk) disable iff (rst)
        idle && !start_now |=> flags == 4'h0;
    endproperty
    a_flags_clear: assert property (p_flags_clear)
        else $error("cause flags not cleared when off");

endmodule // pmsq_sequencer

`default_nettype wire

// ### dv/pmsq_host_model.sv
// Host processor model answering the power acknowledge handshake
`timescale 1ns/1ps
`default_nettype none
module pmsq_host_model (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Device side
    input  wire logic core_on,
    input  wire logic reset_n_oe,
    output logic      host_ack_pin,
    // Bench controls
    input  wire logic ack_enable,
    input  wire logic down_req
);
    // An unpowered or held host cannot drive its ack pin high
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            host_ack_pin <= 1'h0;
        end else begin
            host_ack_pin <= #1 ack_enable && core_on && !reset_n_oe
                            && !down_req;
        end
    end
endmodule // pmsq_host_model
`default_nettype wire

// ### dv/pmsq_sequencer_tb_top.sv
// Self-checking bench for the power mode sequencer
`timescale 1ns/1ps
`default_nettype none
module pmsq_sequencer_tb_top;
    import pmsq_pkg::*;
    localparam int T = 4;
    logic clk, rst, push_button_wake, adapter_supply_in, usb_supply_detect;
    logic host_ack_pin, above_lockout_level, above_battery_alarm_level;
    logic above_battery_low_level, reg_wr, references_en, linear_reg_en;
    logic core_switcher_en, second_switcher_en, third_switcher_en;
    logic charger_default_mode, system_reset_n_out, system_reset_n_oe;
    logic button_status_out_out, button_status_out_oe, ack_enable, down_req;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rv;
    logic [5:0] en, prev;
    int n_errors = 0, tests_run = 0, cycles = 0, t_ab, seed = 42;
    int t_rise [6];
    int t_fall [6];
    int dly [5] = '{LINEAR_REG_DELAY_MS, CORE_DELAY_MS, SECOND_DELAY_MS,
                    THIRD_DELAY_MS, RESET_RELEASE_DELAY_MS};
    assign en = {references_en, ~system_reset_n_oe, third_switcher_en,
                 second_switcher_en, core_switcher_en, linear_reg_en};
    pmsq_sequencer #(.TICK_CYCLES(T)) DUT (.clk, .rst, .push_button_wake,
        .adapter_supply_in, .usb_supply_detect, .host_ack_pin,
        .above_lockout_level, .above_battery_alarm_level,
        .above_battery_low_level, .reg_addr, .reg_wr, .reg_wdata, .reg_rdata,
        .references_en, .linear_reg_en, .core_switcher_en,
        .second_switcher_en, .third_switcher_en, .charger_default_mode,
        .system_reset_n_out, .system_reset_n_oe, .button_status_out_out,
        .button_status_out_oe);
    pmsq_host_model HOST (.clk, .rst, .core_on(core_switcher_en),
        .reset_n_oe(system_reset_n_oe), .host_ack_pin, .ack_enable,
        .down_req);
    // 200 MHz clock
    initial begin
        clk = 1'h0;
        forever #2.5 clk = ~clk;
    end
    // Edge times of each output; the ceiling cuts a hang short
    always @(posedge clk) begin
        cycles++;
        for (int i = 0; i < 6; i++) begin
            if (en[i] && !prev[i]) t_rise[i] = cycles;
            if (!en[i] && prev[i]) t_fall[i] = cycles;
        end
        prev = en;
        if (cycles > 20000) begin
            n_errors++;
            test_done();
        end
    end
    function automatic int on_t(int d); return (6 + d) * T; endfunction
    function automatic int off_t(int d); return (64 - d) * T; endfunction
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED %s expected %0h seen %0h", n, e, g);
        end
    endtask
    // Times carry tolerance: pin sync and tick phase are not pinned down
    task automatic near(string n, int e, int g);
        tests_run++;
        if (g < e - 2 * T || g > e + 2 * T) begin
            n_errors++;
            $display("CHECK FAILED %s expected %0d seen %0d", n, e, g);
        end
    endtask
    task automatic ticks(int n); repeat (n * T) @(posedge clk); #1; endtask
    task automatic rd(logic [7:0] a);
        @(posedge clk) #1 reg_addr = a;
        repeat (2) @(posedge clk);
        #1 rv = reg_rdata;
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge clk) #1 reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'h1;
        @(posedge clk) #1 reg_wr = 1'h0;
    endtask
    task automatic abort_chk;
        wait (!system_reset_n_oe);
        wait (system_reset_n_oe);
        t_ab = cycles;
        near("release", on_t(dly[4]), t_rise[4] - t_rise[5]);
        wait (!linear_reg_en);
        near("abort gap", 2 * T, cycles - t_ab);
        ticks(1);
    endtask
    task test_done;
        $display("errors %0d checks %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // Main sequence: insertion, button, down, three aborts
    initial begin
        {reg_addr, reg_wdata, reg_wr, prev, down_req, rst} = '1;
        {reg_addr, reg_wdata, reg_wr, prev, down_req} = '0;
        {adapter_supply_in, usb_supply_detect} = 2'h0;
        {above_lockout_level, above_battery_alarm_level} = 2'h3;
        {above_battery_low_level, push_button_wake, ack_enable} = 3'h7;
        repeat (12) @(posedge clk);
        chk("reset pin", 1, system_reset_n_oe);
        #1 rst = 1'h0;
        wait (!system_reset_n_oe);
        ticks(1);
        for (int i = 0; i < 5; i++)
            near("on", on_t(dly[i]), t_rise[i] - t_rise[5]);
        rd(REG_POWER_ON_EVENT);
        chk("cause", 8'h08, rv);
        push_button_wake = 1'h0;
        ticks(40);
        chk("status", 1, button_status_out_oe);
        chk("still on", 0, system_reset_n_oe);
        push_button_wake = 1'h1;
        ticks(40);
        chk("status", 0, button_status_out_oe);
        chk("pins", 0, {system_reset_n_out, button_status_out_out});
        repeat (4) begin
            rv = 8'h01 | 8'($random(seed));
            wr(rv, 8'($random(seed)));
            rd(rv);
            chk("unmapped", 0, rv);
        end
        wr(REG_POWER_ON_EVENT, 8'hFF);
        rd(REG_POWER_ON_EVENT);
        chk("ack bit", 8'h18, rv);
        wr(REG_POWER_ON_EVENT, 8'hEF);
        rd(REG_POWER_ON_EVENT);
        chk("ack bit", 8'h08, rv);
        down_req = 1'h1;
        t_ab = cycles;
        wait (!references_en);
        ticks(1);
        for (int i = 0; i < 5; i++)
            near("off", off_t(dly[i]), t_fall[i] - t_ab);
        rd(REG_POWER_ON_EVENT);
        chk("cleared", 0, rv);
        chk("standby pin", 1, system_reset_n_oe);
        {down_req, ack_enable, push_button_wake} = 3'h0;
        wait (references_en);
        rd(REG_POWER_ON_EVENT);
        chk("cause", 8'h04, rv);
        abort_chk();
        chk("chg", 0, charger_default_mode);
        {push_button_wake, adapter_supply_in} = 2'h3;
        wait (references_en);
        rd(REG_POWER_ON_EVENT);
        chk("cause", 8'h02, rv);
        abort_chk();
        chk("chg", 1, charger_default_mode);
        adapter_supply_in = 1'h0;
        ticks(40);
        chk("chg", 0, charger_default_mode);
        {above_battery_alarm_level, usb_supply_detect} = 2'h1;
        ticks(40);
        chk("usb wait", 0, references_en);
        above_battery_alarm_level = 1'h1;
        wait (references_en);
        rd(REG_POWER_ON_EVENT);
        chk("cause", 8'h01, rv);
        abort_chk();
        chk("chg", 1, charger_default_mode);
        test_done();
    end
endmodule // pmsq_sequencer_tb_top
`default_nettype wire
